// File: flash_params.svh
// Named constants for the serial flash command front end.
// Assumes it is included by bare name wherever a constant is needed.
`ifndef FLASH_PARAMS_SVH
`define FLASH_PARAMS_SVH

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define OP_QUAD_ENTER  8'h35
`define OP_QUAD_RESET  8'hf5
`define OP_CRC         8'h9b
`define OP_READ        8'h03
`define OP_RD_STATUS   8'h05
`define OP_RD_FLAG     8'h70
`define OP_PROGRAM     8'h02
`define OP_SECT_ERASE  8'hd8
`define OP_SUB_ERASE   8'h20
`define OP_BULK_ERASE  8'hc7
`define OP_WR_STATUS   8'h01
`define OP_WR_NVCFG    8'hb1
`define OP_PROG_OTP    8'h42
`define OP_WR_VCFG     8'h81
`define OP_WR_EVCFG    8'h61
`define OP_WR_ENABLE   8'h06
`define OP_WR_DISABLE  8'h04
`define OP_CLR_FLAG    8'h50
`define OP_WR_EXTADDR  8'hc5
`define OP_WR_LOCK     8'he5
`define OP_SUSPEND     8'h75
`define OP_RESUME      8'h7a

// ----------------------------------------------------------------
// Check sequence and command frame layout
// ----------------------------------------------------------------
`define CRC_SUBCODE    8'h27
`define CRC_OPT_FULL   8'hff
`define CRC_OPT_RANGE  8'hfe
`define CRC_POLY       64'h42f0e1eba9ea3693
`define CRC_INIT       64'h0000000000000000
`define IDX_OPCODE     5'h00
`define IDX_SUB        5'h01
`define IDX_OPT        5'h02
`define IDX_CRC_FIRST  5'h03
`define IDX_CRC_LAST   5'h0a
`define IDX_START_LAST 5'h0e
`define IDX_STOP_LAST  5'h12
`define IDX_ADDR_LAST  5'h03
`define LEN_CRC_FULL   5'h0b
`define LEN_CRC_RANGE  5'h13
`define BYTE_CNT_MAX   5'h1f
`define SECT_HI        23
`define SECT_LO        16

`endif

// File: flash_pkg.sv
// Types shared by the flash command front end.
// Assumes nothing beyond a SystemVerilog compiler.
package flash_pkg;

	// ----------------------------------------------------------------
	// Device states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_STANDBY,
		ST_PROG_ERASE,
		ST_PGM_SUSPEND,
		ST_ERS_SUSPEND
	} dev_state_t;

endpackage

// File: sync3.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes each bit of din is asynchronous to clk.
`timescale 1ns/1ps
module sync3 #(
	parameter int W = 1
) (
	// Clock and reset.
	input  wire logic         clk,
	input  wire logic         resetn,
	// Pins in, filtered levels out.
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);

	logic [W-1:0] s1_ff;
	logic [W-1:0] s2_ff;
	logic [W-1:0] s3_ff;
	logic [W-1:0] filt_ff;

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			s1_ff   <= '1;
			s2_ff   <= '1;
			s3_ff   <= '1;
			filt_ff <= '1;
		end
		else
		begin
			s1_ff <= din;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			for (int i = 0; i < W; i++)
			begin
				if (s2_ff[i] == s3_ff[i])
					filt_ff[i] <= s3_ff[i];
			end
		end
	end

	assign dout = filt_ff;

endmodule // sync3

// File: crc64_byte.sv
// One byte step of the 64-bit check sum, least significant bit first.
// Assumes the caller holds the running value in its own register.
`timescale 1ns/1ps
`include "flash_params.svh"
module crc64_byte (
	// Running value and next data byte.
	input  wire logic [63:0] crc_in,
	input  wire logic [7:0]  data,
	// Value after the byte.
	output logic      [63:0] crc_out
);

	always_comb
	begin
		logic fb;
		fb      = 1'b0;
		crc_out = crc_in;
		for (int i = 0; i < 8; i++)
		begin
			fb      = crc_out[63] ^ data[i];
			crc_out = {crc_out[62:0], 1'b0} ^ (fb ? `CRC_POLY : 64'h0);
		end
	end

endmodule // crc64_byte

// File: flash_cmd_ctrl.sv
// Command front end of a serial flash: framing, state gating, check sum.
// Assumes chip select, serial clock and data lines are raw pins, and the
// array side answers mem_req with one mem_valid pulse per byte.
`timescale 1ns/1ps
`include "flash_params.svh"
module flash_cmd_ctrl
	import flash_pkg::*;
#(
	parameter logic [31:0] ARRAY_BYTES = 32'h1000_0000
) (
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        resetn,
	// Serial pins.
	input  wire logic        cs_n,
	input  wire logic        sclk,
	input  wire logic [3:0]  serial_data_lines_in,
	output logic      [3:0]  serial_data_lines_out,
	output logic      [3:0]  serial_data_lines_oe,
	// Mode and array progress.
	input  wire logic        address_only_read_mode,
	input  wire logic        op_done,
	// Array byte port.
	output logic             mem_req,
	output logic      [31:0] mem_addr,
	input  wire logic        mem_valid,
	input  wire logic [7:0]  mem_data,
	// Accepted and refused commands.
	output logic             cmd_go,
	output logic             cmd_reject,
	output logic      [7:0]  cmd_code,
	output logic      [23:0] cmd_addr,
	// Status.
	output logic             quad_mode,
	output logic             status_busy,
	output logic             crc_busy,
	output logic             crc_pass,
	output logic             crc_fail,
	output logic             prog_fail_flag,
	output dev_state_t       dev_state
);

	// ----------------------------------------------------------------
	// Pin sampling and edges
	// ----------------------------------------------------------------
	logic [5:0]  pins;
	logic        cs_prev_ff;
	logic        sclk_prev_ff;
	logic        cs_rise;
	logic        cs_fall;
	logic        sclk_rise;
	logic        sclk_fall;

	sync3 #(.W(6)) u_sync (
		.clk    (clk),
		.resetn (resetn),
		.din    ({cs_n, sclk, serial_data_lines_in}),
		.dout   (pins)
	);

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			cs_prev_ff   <= 1'b1;
			sclk_prev_ff <= 1'b0;
		end
		else
		begin
			cs_prev_ff   <= pins[5];
			sclk_prev_ff <= pins[4];
		end
	end

	assign cs_rise   = pins[5] & ~cs_prev_ff;
	assign cs_fall   = ~pins[5] & cs_prev_ff;
	assign sclk_rise = ~pins[5] & pins[4] & ~sclk_prev_ff;
	assign sclk_fall = ~pins[5] & ~pins[4] & sclk_prev_ff;

	// ----------------------------------------------------------------
	// Byte assembly
	// ----------------------------------------------------------------
	logic        quad_ff;
	logic [7:0]  shift_ff;
	logic [2:0]  bit_cnt_ff;
	logic [4:0]  byte_cnt_ff;
	logic [3:0]  step;
	logic [3:0]  nxt_bits;
	logic [7:0]  nxt_byte;
	logic        byte_done;
	logic [7:0]  opcode_ff;
	logic [7:0]  sub_ff;
	logic [7:0]  opt_ff;
	logic [63:0] exp_crc_ff;
	logic [31:0] start_ff;
	logic [31:0] stop_ff;
	logic [23:0] addr_ff;

	assign step      = quad_ff ? 4'h4 : 4'h1;
	assign nxt_bits  = {1'b0, bit_cnt_ff} + step;
	assign byte_done = sclk_rise & nxt_bits[3];
	assign nxt_byte  = quad_ff ? {shift_ff[3:0], pins[3:0]} : {shift_ff[6:0], pins[0]};

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			shift_ff    <= 8'h00;
			bit_cnt_ff  <= 3'h0;
			byte_cnt_ff <= 5'h00;
			opcode_ff   <= 8'h00;
		end
		else if (cs_fall)
		begin
			bit_cnt_ff  <= 3'h0;
			byte_cnt_ff <= address_only_read_mode ? 5'h01 : 5'h00;
			opcode_ff   <= address_only_read_mode ? `OP_READ : 8'h00;
		end
		else if (sclk_rise)
		begin
			shift_ff   <= nxt_byte;
			bit_cnt_ff <= nxt_bits[2:0];
			if (byte_done && byte_cnt_ff != `BYTE_CNT_MAX)
				byte_cnt_ff <= byte_cnt_ff + 5'h01;
			if (byte_done && byte_cnt_ff == `IDX_OPCODE)
				opcode_ff <= nxt_byte;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			sub_ff     <= 8'h00;
			opt_ff     <= 8'h00;
			exp_crc_ff <= 64'h0;
			start_ff   <= 32'h0;
			stop_ff    <= 32'h0;
			addr_ff    <= 24'h0;
		end
		else if (byte_done)
		begin
			if (byte_cnt_ff == `IDX_SUB)
				sub_ff <= nxt_byte;
			if (byte_cnt_ff == `IDX_OPT)
				opt_ff <= nxt_byte;
			if (byte_cnt_ff >= `IDX_CRC_FIRST && byte_cnt_ff <= `IDX_CRC_LAST)
				exp_crc_ff <= {nxt_byte, exp_crc_ff[63:8]};
			if (byte_cnt_ff > `IDX_CRC_LAST && byte_cnt_ff <= `IDX_START_LAST)
				start_ff <= {nxt_byte, start_ff[31:8]};
			if (byte_cnt_ff > `IDX_START_LAST && byte_cnt_ff <= `IDX_STOP_LAST)
				stop_ff <= {nxt_byte, stop_ff[31:8]};
			if (byte_cnt_ff != `IDX_OPCODE && byte_cnt_ff <= `IDX_ADDR_LAST)
				addr_ff <= {addr_ff[15:0], nxt_byte};
		end
	end

	// Protocol width changes as soon as the code byte is in.
	always_ff @(posedge clk)
	begin
		if (!resetn)
			quad_ff <= 1'b0;
		else if (byte_done && byte_cnt_ff == `IDX_OPCODE && nxt_byte == `OP_QUAD_ENTER)
			quad_ff <= 1'b1;
		else if (byte_done && byte_cnt_ff == `IDX_OPCODE && nxt_byte == `OP_QUAD_RESET)
			quad_ff <= 1'b0;
	end

	// ----------------------------------------------------------------
	// State gating
	// ----------------------------------------------------------------
	dev_state_t  state_ff;
	logic        crc_busy_ff;

	function automatic logic gate_ok(input logic [7:0] op, input dev_state_t st);
		case (op)
			`OP_RD_STATUS, `OP_RD_FLAG, `OP_QUAD_ENTER, `OP_QUAD_RESET:
				gate_ok = 1'b1;
			`OP_READ:
				gate_ok = (st != ST_PROG_ERASE);
			`OP_PROGRAM:
				gate_ok = (st == ST_STANDBY) || (st == ST_ERS_SUSPEND);
			`OP_SECT_ERASE, `OP_SUB_ERASE:
				gate_ok = (st == ST_STANDBY);
			`OP_WR_STATUS, `OP_WR_NVCFG, `OP_PROG_OTP, `OP_BULK_ERASE, `OP_CRC:
				gate_ok = (st == ST_STANDBY);
			`OP_WR_VCFG, `OP_WR_EVCFG, `OP_WR_ENABLE, `OP_WR_DISABLE, `OP_CLR_FLAG, `OP_WR_EXTADDR, `OP_WR_LOCK:
				gate_ok = (st != ST_PROG_ERASE);
			`OP_SUSPEND:
				gate_ok = (st == ST_PROG_ERASE);
			`OP_RESUME:
				gate_ok = (st == ST_PGM_SUSPEND) || (st == ST_ERS_SUSPEND);
			default:
				gate_ok = (st == ST_STANDBY);
		endcase
	endfunction

	logic        status_op;
	logic        op_ok;
	logic        crc_form_ok;
	logic        crc_full;
	logic        frame_ok;
	logic        exec;
	logic        blocked;
	logic        accept;
	logic        rd_go;
	logic        rd_ok;
	logic [7:0]  ers_sector_ff;
	logic        ers_is_sub_ff;
	logic        nested_ff;

	assign status_op   = (opcode_ff == `OP_RD_STATUS) || (opcode_ff == `OP_RD_FLAG);
	assign op_ok       = crc_busy_ff ? status_op : gate_ok(opcode_ff, state_ff);
	assign crc_full    = (opt_ff == `CRC_OPT_FULL);
	assign crc_form_ok = (opcode_ff != `OP_CRC) || ((sub_ff == `CRC_SUBCODE) &&
		((crc_full && byte_cnt_ff == `LEN_CRC_FULL) ||
		(opt_ff == `CRC_OPT_RANGE && byte_cnt_ff == `LEN_CRC_RANGE)));
	assign frame_ok    = (bit_cnt_ff == 3'h0) && (byte_cnt_ff != 5'h00) && (opcode_ff != `OP_READ) &&
		(opcode_ff != `OP_QUAD_ENTER) && (opcode_ff != `OP_QUAD_RESET);
	assign exec        = cs_rise & frame_ok;
	assign blocked     = (opcode_ff == `OP_PROGRAM) && (state_ff == ST_ERS_SUSPEND) &&
		(addr_ff[`SECT_HI:`SECT_LO] == ers_sector_ff);
	assign accept      = exec & op_ok & crc_form_ok & ~blocked;
	assign rd_go       = byte_done && byte_cnt_ff == `IDX_ADDR_LAST && opcode_ff == `OP_READ;
	assign rd_ok       = rd_go & op_ok;

	// Device state moves only on accepted commands and array completion.
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			state_ff      <= ST_STANDBY;
			ers_sector_ff <= 8'h00;
			ers_is_sub_ff <= 1'b0;
			nested_ff     <= 1'b0;
		end
		else
		begin
			case (state_ff)
				ST_STANDBY:
				begin
					if (accept && (opcode_ff == `OP_SECT_ERASE || opcode_ff == `OP_SUB_ERASE ||
						opcode_ff == `OP_BULK_ERASE))
					begin
						state_ff      <= ST_PROG_ERASE;
						ers_sector_ff <= addr_ff[`SECT_HI:`SECT_LO];
						ers_is_sub_ff <= (opcode_ff == `OP_SUB_ERASE);
						nested_ff     <= 1'b0;
					end
					else if (accept && opcode_ff == `OP_PROGRAM)
					begin
						state_ff      <= ST_PROG_ERASE;
						ers_is_sub_ff <= 1'b1;
						nested_ff     <= 1'b0;
					end
				end
				ST_PROG_ERASE:
				begin
					if (op_done)
						state_ff <= nested_ff ? ST_ERS_SUSPEND : ST_STANDBY;
					else if (accept && opcode_ff == `OP_SUSPEND)
						state_ff <= (ers_is_sub_ff || nested_ff) ? ST_PGM_SUSPEND : ST_ERS_SUSPEND;
				end
				ST_PGM_SUSPEND:
				begin
					if (accept && opcode_ff == `OP_RESUME)
						state_ff <= ST_PROG_ERASE;
				end
				ST_ERS_SUSPEND:
				begin
					if (accept && opcode_ff == `OP_RESUME)
					begin
						state_ff  <= ST_PROG_ERASE;
						nested_ff <= 1'b0;
					end
					else if (accept && opcode_ff == `OP_PROGRAM)
					begin
						state_ff  <= ST_PROG_ERASE;
						nested_ff <= 1'b1;
					end
				end
				default:
					state_ff <= ST_STANDBY;
			endcase
		end
	end

	// Failure flag: a new event wins over a clear in the same cycle.
	logic        fail_ff;

	always_ff @(posedge clk)
	begin
		if (!resetn)
			fail_ff <= 1'b0;
		else if (exec && blocked && op_ok)
			fail_ff <= 1'b1;
		else if (accept && opcode_ff == `OP_CLR_FLAG)
			fail_ff <= 1'b0;
	end

	logic        go_ff;
	logic        rej_ff;
	logic [7:0]  code_ff;
	logic [23:0] caddr_ff;

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			go_ff    <= 1'b0;
			rej_ff   <= 1'b0;
			code_ff  <= 8'h00;
			caddr_ff <= 24'h0;
		end
		else
		begin
			go_ff  <= accept | rd_ok;
			rej_ff <= (exec & ~accept) | (rd_go & ~rd_ok);
			if (exec || rd_go)
			begin
				code_ff  <= opcode_ff;
				caddr_ff <= rd_go ? {addr_ff[15:0], nxt_byte} : addr_ff;
			end
		end
	end

	// ----------------------------------------------------------------
	// Check sum engine and array port
	// ----------------------------------------------------------------
	logic        pend_ff;
	logic [31:0] maddr_ff;
	logic [31:0] end_ff;
	logic [63:0] crc_ff;
	logic [63:0] nxt_crc;
	logic        pass_ff;
	logic        cfail_ff;
	logic        crc_start;
	logic        crc_last;
	logic        rd_active_ff;
	logic [31:0] rd_addr_ff;
	logic [7:0]  out_ff;
	logic [2:0]  out_cnt_ff;
	logic        out_full_ff;
	logic [3:0]  dq_ff;
	logic [3:0]  nxt_out_cnt;

	crc64_byte u_crc (
		.crc_in  (crc_ff),
		.data    (mem_data),
		.crc_out (nxt_crc)
	);

	assign crc_start = accept && opcode_ff == `OP_CRC && !pend_ff;
	assign crc_last  = crc_busy_ff && mem_valid && pend_ff && maddr_ff >= end_ff;

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			crc_busy_ff <= 1'b0;
			crc_ff      <= `CRC_INIT;
			end_ff      <= 32'h0;
			pass_ff     <= 1'b0;
			cfail_ff    <= 1'b0;
		end
		else if (crc_start)
		begin
			crc_busy_ff <= 1'b1;
			crc_ff      <= `CRC_INIT;
			end_ff      <= crc_full ? ARRAY_BYTES - 32'h1 : stop_ff;
			pass_ff     <= 1'b0;
			cfail_ff    <= 1'b0;
		end
		else if (crc_busy_ff && mem_valid && pend_ff)
		begin
			crc_ff <= nxt_crc;
			if (crc_last)
			begin
				crc_busy_ff <= 1'b0;
				pass_ff     <= (nxt_crc == exp_crc_ff);
				cfail_ff    <= (nxt_crc != exp_crc_ff);
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			pend_ff    <= 1'b0;
			maddr_ff   <= 32'h0;
			rd_addr_ff <= 32'h0;
		end
		else if (crc_start)
		begin
			pend_ff  <= 1'b1;
			maddr_ff <= crc_full ? 32'h0 : start_ff;
		end
		else if (pend_ff)
		begin
			if (mem_valid)
			begin
				pend_ff  <= crc_busy_ff && !crc_last;
				maddr_ff <= maddr_ff + 32'h1;
			end
		end
		else if (rd_ok)
			rd_addr_ff <= {8'h00, addr_ff[15:0], nxt_byte};
		else if (rd_active_ff && !out_full_ff && !crc_busy_ff)
		begin
			pend_ff    <= 1'b1;
			maddr_ff   <= rd_addr_ff;
			rd_addr_ff <= rd_addr_ff + 32'h1;
		end
	end

	// Read data leaves on falling clock edges over the active lines.
	assign nxt_out_cnt = {1'b0, out_cnt_ff} + step;

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			rd_active_ff <= 1'b0;
			out_ff       <= 8'h00;
			out_cnt_ff   <= 3'h0;
			out_full_ff  <= 1'b0;
			dq_ff        <= 4'h0;
		end
		else if (cs_rise || cs_fall)
		begin
			rd_active_ff <= 1'b0;
			out_full_ff  <= 1'b0;
		end
		else
		begin
			if (rd_ok)
				rd_active_ff <= 1'b1;
			if (rd_active_ff && pend_ff && mem_valid && !crc_busy_ff)
			begin
				out_ff      <= mem_data;
				out_cnt_ff  <= 3'h0;
				out_full_ff <= 1'b1;
			end
			else if (sclk_fall && out_full_ff)
			begin
				dq_ff       <= quad_ff ? out_ff[7:4] : {2'b00, out_ff[7], 1'b0};
				out_ff      <= quad_ff ? {out_ff[3:0], 4'h0} : {out_ff[6:0], 1'b0};
				out_cnt_ff  <= nxt_out_cnt[2:0];
				out_full_ff <= !nxt_out_cnt[3];
			end
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign serial_data_lines_out = dq_ff;
	assign serial_data_lines_oe  = rd_active_ff ? (quad_ff ? 4'hf : 4'h2) : 4'h0;
	assign mem_req        = pend_ff;
	assign mem_addr       = maddr_ff;
	assign cmd_go         = go_ff;
	assign cmd_reject     = rej_ff;
	assign cmd_code       = code_ff;
	assign cmd_addr       = caddr_ff;
	assign quad_mode      = quad_ff;
	assign status_busy    = crc_busy_ff | (state_ff == ST_PROG_ERASE);
	assign crc_busy       = crc_busy_ff;
	assign crc_pass       = pass_ff;
	assign crc_fail       = cfail_ff;
	assign prog_fail_flag = fail_ff;
	assign dev_state      = state_ff;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_quad_enter_now: assert property (@(posedge clk) disable iff (!resetn)
		byte_done && byte_cnt_ff == `IDX_OPCODE && nxt_byte == `OP_QUAD_ENTER |=> quad_mode)
		else $error("quad mode not entered");
	a_quad_leave_now: assert property (@(posedge clk) disable iff (!resetn)
		byte_done && byte_cnt_ff == `IDX_OPCODE && nxt_byte == `OP_QUAD_RESET |=> !quad_mode)
		else $error("quad mode not left");
	a_crc_zero_start: assert property (@(posedge clk) disable iff (!resetn)
		crc_start |=> crc_ff == 64'h0 && crc_busy)
		else $error("check sum did not start from zero");
	a_crc_verdict: assert property (@(posedge clk) disable iff (!resetn)
		crc_last |=> crc_pass == (crc_ff == exp_crc_ff) && crc_fail != crc_pass)
		else $error("check verdict wrong");
	a_crc_on_cs: assert property (@(posedge clk) disable iff (!resetn)
		$rose(crc_busy) |-> $past(cs_rise))
		else $error("check started without chip select rise");
	a_suspend_gate: assert property (@(posedge clk) disable iff (!resetn)
		cmd_go && cmd_code == `OP_SUSPEND |-> $past(state_ff) == ST_PROG_ERASE)
		else $error("suspend accepted outside program or erase");
	a_erase_gate: assert property (@(posedge clk) disable iff (!resetn)
		cmd_go && (cmd_code == `OP_SECT_ERASE || cmd_code == `OP_SUB_ERASE) |-> $past(state_ff) == ST_STANDBY)
		else $error("erase accepted outside standby");
	a_status_always: assert property (@(posedge clk) disable iff (!resetn)
		exec && status_op |=> cmd_go && !cmd_reject)
		else $error("status read refused");
	a_blocked_prog: assert property (@(posedge clk) disable iff (!resetn)
		exec && blocked |=> prog_fail_flag && !cmd_go && state_ff == ST_ERS_SUSPEND)
		else $error("program to suspended sector not blocked");
	a_busy_shown: assert property (@(posedge clk) disable iff (!resetn)
		crc_busy |-> status_busy && !crc_pass && !crc_fail)
		else $error("busy or verdict wrong during check");
	a_verdict_hold: assert property (@(posedge clk) disable iff (!resetn)
		!crc_start && !crc_last |=> $stable(crc_pass) && $stable(crc_fail))
		else $error("check verdict changed outside a check");

	c_crc_pass: cover property (@(posedge clk) disable iff (!resetn) $rose(crc_pass));
	c_suspend: cover property (@(posedge clk) disable iff (!resetn) state_ff == ST_ERS_SUSPEND);
	c_quad_read: cover property (@(posedge clk) disable iff (!resetn) rd_ok && quad_mode);

endmodule // flash_cmd_ctrl

// File: spi_host_model.sv
// Host side of the serial link: frames queued bytes under chip select.
// Assumes the caller fills tx_q and then calls frame.
`timescale 1ns/1ps
module spi_host_model (
	// Host pins.
	output logic       cs_n,
	output logic       sclk,
	output logic [3:0] dq
);
	logic [7:0] tx_q[$];
	logic [7:0] b;
	initial
	begin
		cs_n = 1'b1;
		sclk = 1'b0;
		dq   = 4'ha;
	end
	// Clock stands low outside frames; bits change while clock is low.
	task automatic frame(input logic quad);
		cs_n = 1'b0;
		while (tx_q.size() > 0)
		begin
			b = tx_q.pop_front();
			for (int i = 7; i >= 0; i -= (quad ? 4 : 1))
			begin
				#31.25;
				if (quad)
					dq = b[i -: 4];
				else
					dq = {~dq[3:1], b[i]};
				#31.25 sclk = 1'b1;
				#62.5 sclk = 1'b0;
			end
		end
		#31.25 dq = ~dq;
		cs_n = 1'b1;
		#200;
	endtask
endmodule // spi_host_model

// File: flash_crc_check_and_state_gating_test.sv
// Self-checking bench for the flash command front end.
// Assumes the host model and an array model answering mem_req.
`timescale 1ns/1ps
`include "flash_params.svh"
module flash_crc_check_and_state_gating_test;
	import flash_pkg::*;
	logic        clk = 1'b0, resetn = 1'b0, op_done = 1'b0, mem_valid = 1'b0;
	logic        address_only_read_mode = 1'b0, busy_seen = 1'b0;
	logic [3:0]  oe_seen = 4'h0;
	logic        cs_n, sclk, mem_req, cmd_go, cmd_reject, quad_mode;
	logic        status_busy, crc_busy, crc_pass, crc_fail, prog_fail_flag;
	logic [3:0]  dq_in, dq_out, dq_oe;
	logic [7:0]  mem_data = 8'h00, cmd_code;
	logic [23:0] cmd_addr;
	logic [31:0] mem_addr;
	dev_state_t  dev_state;
	int          errors = 0, samples_checked = 0, go_cnt, rej_cnt;
	logic [8:0]  rows [13] = '{9'h105, 9'h170, 9'h106, 9'h104, 9'h150, 9'h181, 9'h161,
		9'h1c5, 9'h1e5, 9'h1b1, 9'h101, 9'h075, 9'h07a};
	always #2 clk = ~clk;
	spi_host_model host (.cs_n(cs_n), .sclk(sclk), .dq(dq_in));
	flash_cmd_ctrl #(.ARRAY_BYTES(32'h0000_0010)) dut (.clk(clk), .resetn(resetn), .cs_n(cs_n),
		.sclk(sclk), .serial_data_lines_in(dq_in), .serial_data_lines_out(dq_out),
		.serial_data_lines_oe(dq_oe), .address_only_read_mode(address_only_read_mode),
		.op_done(op_done), .mem_req(mem_req), .mem_addr(mem_addr), .mem_valid(mem_valid),
		.mem_data(mem_data), .cmd_go(cmd_go), .cmd_reject(cmd_reject), .cmd_code(cmd_code),
		.cmd_addr(cmd_addr), .quad_mode(quad_mode), .status_busy(status_busy),
		.crc_busy(crc_busy), .crc_pass(crc_pass), .crc_fail(crc_fail),
		.prog_fail_flag(prog_fail_flag), .dev_state(dev_state));
	// ----------------------------------------------------------------
	// Array model and pulse monitor
	// ----------------------------------------------------------------
	always @(negedge clk)
	begin
		mem_valid <= mem_req && !mem_valid;
		mem_data  <= {mem_addr[3:0], ~mem_addr[3:0]};
	end
	always @(posedge clk)
	begin
		go_cnt  += cmd_go;
		rej_cnt += cmd_reject;
		oe_seen |= dq_oe;
		if (crc_busy && status_busy)
			busy_seen = 1'b1;
	end
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic run(input logic [7:0] q[$], input logic quad, input int eg, input int er);
		go_cnt = 0;
		rej_cnt = 0;
		host.tx_q = q;
		host.frame(quad);
		chk(go_cnt, eg);
		chk(rej_cnt, er);
	endtask
	task automatic done_pulse();
		@(negedge clk) op_done = 1'b1;
		@(negedge clk) op_done = 1'b0;
		repeat (2) @(negedge clk);
	endtask
	function automatic logic [63:0] crc_ref(input int lo, input int hi);
		logic [63:0] c;
		logic [7:0]  d;
		c = 64'h0;
		for (int a = lo; a <= hi; a++)
		begin
			d = {a[3:0], ~a[3:0]};
			for (int i = 0; i < 8; i++)
				c = {c[62:0], 1'b0} ^ ((c[63] ^ d[i]) ? `CRC_POLY : 64'h0);
		end
		return c;
	endfunction
	task automatic check(input logic [7:0] opt, input logic [63:0] e, input logic [31:0] st, sp);
		logic [7:0] q[$];
		q = '{8'h9b, 8'h27, opt};
		for (int i = 0; i < 8; i++)
			q.push_back(e[8*i +: 8]);
		for (int i = 0; i < 8 && opt == 8'hfe; i++)
			q.push_back(i < 4 ? st[8*i +: 8] : sp[8*(i-4) +: 8]);
		run(q, 1'b0, 1, 0);
		for (int i = 0; i < 400 && crc_busy !== 1'b0; i++)
			@(negedge clk);
	endtask
	task automatic results();
		$display("errors %0d samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		#200000;
		errors++;
		results();
	end
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (4) @(negedge clk);
		chk({cmd_go, crc_pass, crc_fail, quad_mode, mem_req, dev_state}, 64'h0);
		resetn = 1'b1;
		repeat (10) @(negedge clk);
		foreach (rows[i])
			run('{rows[i][7:0]}, 1'b0, rows[i][8], !rows[i][8]);
		chk(dev_state, ST_STANDBY);
		run('{8'h02, 8'h01, 8'h00, 8'h00, 8'ha5}, 1'b0, 1, 0);
		chk(dev_state, ST_PROG_ERASE);
		run('{8'h03, 8'h01, 8'h00, 8'h00}, 1'b0, 0, 1);
		run('{8'h06}, 1'b0, 0, 1);
		run('{8'hd8, 8'h02, 8'h00, 8'h00}, 1'b0, 0, 1);
		run('{8'h70}, 1'b0, 1, 0);
		run('{8'h75}, 1'b0, 1, 0);
		chk(dev_state, ST_PGM_SUSPEND);
		run('{8'h02, 8'h02, 8'h00, 8'h00, 8'h11}, 1'b0, 0, 1);
		run('{8'h03, 8'h01, 8'h00, 8'h00}, 1'b0, 1, 0);
		run('{8'h75}, 1'b0, 0, 1);
		run('{8'h7a}, 1'b0, 1, 0);
		done_pulse();
		chk(dev_state, ST_STANDBY);
		run('{8'hd8, 8'h05, 8'h00, 8'h00}, 1'b0, 1, 0);
		run('{8'h75}, 1'b0, 1, 0);
		chk(dev_state, ST_ERS_SUSPEND);
		run('{8'h02, 8'h05, 8'h10, 8'h00, 8'h11}, 1'b0, 0, 1);
		chk({prog_fail_flag, dev_state}, {1'b1, ST_ERS_SUSPEND});
		run('{8'h02, 8'h06, 8'h00, 8'h00, 8'h11}, 1'b0, 1, 0);
		done_pulse();
		chk(dev_state, ST_ERS_SUSPEND);
		run('{8'h7a}, 1'b0, 1, 0);
		done_pulse();
		chk(dev_state, ST_STANDBY);
		run('{8'h50}, 1'b0, 1, 0);
		chk(prog_fail_flag, 1'b0);
		run('{8'h35}, 1'b0, 0, 0);
		chk(quad_mode, 1'b1);
		run('{8'h05}, 1'b1, 1, 0);
		oe_seen = 4'h0;
		run('{8'h03, 8'h00, 8'h00, 8'h04}, 1'b1, 1, 0);
		chk({oe_seen, dq_out}, {4'hf, 4'h4});
		run('{8'hf5}, 1'b1, 0, 0);
		chk(quad_mode, 1'b0);
		@(negedge clk) address_only_read_mode = 1'b1;
		oe_seen = 4'h0;
		run('{8'h00, 8'h00, 8'h08}, 1'b0, 1, 0);
		@(negedge clk) address_only_read_mode = 1'b0;
		chk({oe_seen, dq_out, cmd_code, cmd_addr}, {4'h2, 4'h2, 8'h03, 24'h000008});
		chk(mem_addr, 32'h0000_0009);
		run('{8'h9b, 8'h27, 8'h01}, 1'b0, 0, 1);
		check(8'hfe, crc_ref(2, 5), 32'h2, 32'h5);
		chk({crc_pass, crc_fail, busy_seen}, 3'b101);
		check(8'hff, ~crc_ref(0, 15), 32'h0, 32'h0);
		chk({crc_pass, crc_fail}, 2'b01);
		results();
	end
endmodule // flash_crc_check_and_state_gating_test
